// ### hdc_pkg.sv
// hdc_pkg: constants, register map and carrier types of the hub dma controller
`default_nettype none
package hdc_pkg;
  // channel and descriptor pool sizes
  localparam int NCH = 24;
  localparam int NTD = 128;
  localparam int NLVL = 8;
  localparam int DESC_WORDS = 256;
  // apb register offsets (byte addresses)
  localparam logic [11:0] OFS_DESC = 12'h000;
  localparam logic [11:0] OFS_CFG = 12'h400;
  localparam logic [11:0] OFS_TRIG = 12'h480;
  localparam logic [11:0] OFS_PAUSE = 12'h484;
  localparam logic [11:0] OFS_CANCEL = 12'h488;
  localparam logic [11:0] OFS_CTRL = 12'h48C;
  localparam logic [11:0] OFS_BUSY = 12'h490;
  localparam logic [11:0] OFS_PEND = 12'h494;
  localparam logic [11:0] OFS_STAT = 12'h498;
  // spoke decode on the 16-bit hub address
  localparam int SPOKE_MSB = 15;
  localparam int SPOKE_LSB = 13;
  localparam logic [2:0] SPOKE_SRAM = 3'h0;
  localparam logic [2:0] SPOKE_HUB = 3'h2;
  localparam logic [2:0] SPOKE_ANALOG = 3'h3;
  // descriptor pool window seen by dma writes: addr[15:10] selects it
  localparam logic [5:0] DESC_PAGE = 6'h10;
  // level where fairness sharing begins
  localparam logic [2:0] FAIR_LVL = 3'h2;
  localparam logic [2:0] LAST_LVL = 3'h7;
  // per-channel configuration word
  typedef struct packed {
    logic en;
    logic [2:0] prio;
    logic rr_dis;
    logic chain_en;
    logic [4:0] chain_ch;
    logic [6:0] first_td;
  } hdc_ch_cfg_t;
  localparam hdc_ch_cfg_t CFG_RST = '0;
  // descriptor word 0
  typedef struct packed {
    logic [2:0] rsvd;
    logic dst_inc;
    logic src_inc;
    logic irq1_en;
    logic irq0_en;
    logic infinite;
    logic last;
    logic [6:0] next_td;
    logic [15:0] len_m1;
  } hdc_td_ctrl_t;
  // descriptor word 1
  typedef struct packed {
    logic [15:0] dst;
    logic [15:0] src;
  } hdc_td_addr_t;
  // one byte transaction towards the spokes
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] spoke;
    logic [15:0] addr;
    logic [7:0] wdata;
  } hdc_req_t;
  // transaction engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } hdc_state_t;
endpackage : hdc_pkg
`default_nettype wire

// ### hdc_dma_hub.sv
// hdc_dma_hub: 24-channel descriptor dma controller with hub arbiter and spoke decode
//
// The placing of the registers and register access over APB were decided locally.
`default_nettype none
module hdc_dma_hub
  import hdc_pkg::*;
#(
  parameter logic [3:0] STARVE_LIMIT = 4'h8 // conflicts before dma wins once
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic [NCH-1:0] trig_in,
  input wire logic cpu_req,
  input wire logic [15:0] cpu_addr,
  output var logic cpu_gnt,
  output var logic [2:0] cpu_spoke,
  output var hdc_req_t m_req,
  input wire logic m_ready,
  input wire logic [7:0] m_rdata,
  output var logic [NCH-1:0] irq0,
  output var logic [NCH-1:0] irq1,
  output var logic [NCH-1:0] chan_busy
);

  // spoke index of a hub address
  function automatic logic [2:0] spoke_of(input logic [15:0] a);
    return a[SPOKE_MSB:SPOKE_LSB];
  endfunction

  // round robin pick inside one level; fixed channels go first
  function automatic logic [5:0] pick(input logic [NCH-1:0] m, input logic [4:0] ptr,
                                      input logic [NCH-1:0] fixed);
    logic [5:0] r;
    int idx;
    r = '0;
    for (int k = NCH; k >= 1; k--)
    begin
      idx = (int'(ptr) + k) % NCH;
      if (m[idx])
        r = {1'b1, 5'(idx)};
    end
    for (int c = NCH - 1; c >= 0; c--)
    begin
      if (m[c] && fixed[c])
        r = {1'b1, 5'(c)};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0] desc_mem [0:DESC_WORDS-1]; // descriptor pool, two words each
  hdc_ch_cfg_t cfg_reg [NCH]; // channel configuration
  logic [NCH-1:0] pause_reg; // stalled channels
  logic fair_en_reg; // fairness on
  logic [NCH-1:0] pend_reg; // triggered, not yet started
  logic [NCH-1:0] busy_reg; // has a live descriptor
  logic [NCH-1:0] load_reg; // descriptor must be fetched at next grant
  logic [6:0] td_reg [NCH]; // current descriptor per channel
  logic [15:0] rem_reg [NCH]; // bytes left minus one
  logic [15:0] src_reg [NCH]; // running source address
  logic [15:0] dst_reg [NCH]; // running destination address
  hdc_state_t state_reg; // transaction engine state
  logic [4:0] act_reg; // channel owning the engine
  logic [7:0] byte_reg; // byte in flight
  logic [3:0] starve_reg; // cpu conflicts suffered by dma
  logic [4:0] rr_ptr_reg [NLVL]; // last winner per level
  logic [7:0] fair_cnt_reg; // fairness slot counter
  logic [NCH-1:0] trig_s1_reg, trig_s2_reg, trig_s3_reg; // pin synchroniser + edge
  logic [NCH-1:0] cpu_trig, cancel; // one-cycle software strobes

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, answer registered at setup
  logic apb_wr;
  logic [4:0] cfg_idx;
  logic cfg_hit, desc_hit;
  assign apb_wr = psel && penable && pwrite && pready;
  assign cfg_idx = paddr[6:2];
  assign desc_hit = (paddr[11:10] == OFS_DESC[11:10]);
  assign cfg_hit = (paddr[11:7] == OFS_CFG[11:7]) && (int'(cfg_idx) < NCH);
  assign cpu_trig = (apb_wr && paddr == OFS_TRIG) ? pwdata[NCH-1:0] : '0;
  assign cancel = (apb_wr && paddr == OFS_CANCEL) ? pwdata[NCH-1:0] : '0;

  // read data, ready and error, all prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable)
      begin
        if (desc_hit)
          prdata <= desc_mem[paddr[9:2]];
        else if (cfg_hit)
          prdata <= 32'(cfg_reg[cfg_idx]);
        else
          case (paddr)
            OFS_TRIG, OFS_CANCEL: prdata <= '0; // write-only strobes
            OFS_PAUSE: prdata <= 32'(pause_reg);
            OFS_CTRL: prdata <= 32'(fair_en_reg);
            OFS_BUSY: prdata <= 32'(busy_reg);
            OFS_PEND: prdata <= 32'(pend_reg);
            OFS_STAT: prdata <= 32'({state_reg, act_reg});
            default: pslverr <= 1'b1; // unmapped
          endcase
      end
    end
  end

  // software-written control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pause_reg <= '0;
      fair_en_reg <= 1'b0;
      for (int c = 0; c < NCH; c++)
        cfg_reg[c] <= CFG_RST;
    end
    else if (ce && apb_wr)
    begin
      if (cfg_hit)
        cfg_reg[cfg_idx] <= hdc_ch_cfg_t'(pwdata[$bits(hdc_ch_cfg_t)-1:0]);
      if (paddr == OFS_PAUSE)
        pause_reg <= pwdata[NCH-1:0];
      if (paddr == OFS_CTRL)
        fair_en_reg <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger pins: two flops, then rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      trig_s3_reg <= '0;
    end
    else if (ce)
    begin
      trig_s1_reg <= trig_in;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbiter: candidates, levels, fairness slot, round robin
  logic [NCH-1:0] cand, fixed;
  logic [NCH-1:0] lvl_mask [NLVL];
  logic [NLVL-1:0] lvl_any;
  logic [2:0] top_lvl, pref_lvl, use_lvl;
  logic [5:0] sel;
  logic sel_valid;
  logic [4:0] sel_ch;
  always_comb
  begin
    cand = busy_reg & ~pause_reg;
    lvl_any = '0;
    top_lvl = LAST_LVL;
    pref_lvl = LAST_LVL;
    for (int c = 0; c < NCH; c++)
      fixed[c] = cfg_reg[c].rr_dis;
    for (int l = 0; l < NLVL; l++)
    begin
      for (int c = 0; c < NCH; c++)
        lvl_mask[l][c] = cand[c] && cfg_reg[c].en && (int'(cfg_reg[c].prio) == l);
      lvl_any[l] = |lvl_mask[l];
    end
    for (int l = NLVL - 1; l >= 0; l--)
    begin
      if (lvl_any[l])
        top_lvl = 3'(l); // lowest number wins
    end
    // slot k of the counter trailing zeros: level 2 half, 3 quarter, ...
    for (int b = 4; b >= 0; b--)
    begin
      if (fair_cnt_reg[b])
        pref_lvl = 3'(int'(FAIR_LVL) + b);
    end
    // levels 0 and 1 always outrank the fairness slot
    if (fair_en_reg && top_lvl >= FAIR_LVL && lvl_any[pref_lvl])
      use_lvl = pref_lvl;
    else
      use_lvl = top_lvl;
    sel = pick(lvl_mask[use_lvl], rr_ptr_reg[use_lvl], fixed);
  end
  assign sel_valid = sel[5];
  assign sel_ch = sel[4:0];
  logic start;
  assign start = (state_reg == ST_IDLE) && sel_valid;

  // round robin pointers advance per granted transaction, the fairness counter only per grant at level 2 or above with fairness on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fair_cnt_reg <= 8'h01;
      for (int l = 0; l < NLVL; l++)
        rr_ptr_reg[l] <= '0;
    end
    else if (ce && start)
    begin
      rr_ptr_reg[use_lvl] <= sel_ch;
      if (fair_en_reg && use_lvl >= FAIR_LVL)
        fair_cnt_reg <= fair_cnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current transaction addressing
  hdc_td_ctrl_t cur_ctl, ld_ctl;
  hdc_td_addr_t ld_adr;
  logic [15:0] cur_addr;
  logic dst_is_desc, issue_ok, conflict, rd_done, wr_done, last_byte;
  assign cur_ctl = hdc_td_ctrl_t'(desc_mem[{td_reg[act_reg], 1'b0}]);
  assign ld_ctl = hdc_td_ctrl_t'(desc_mem[{td_reg[sel_ch], 1'b0}]);
  assign ld_adr = hdc_td_addr_t'(desc_mem[{td_reg[sel_ch], 1'b1}]);
  assign cur_addr = (state_reg == ST_WRITE) ? dst_reg[act_reg] : src_reg[act_reg];
  assign dst_is_desc = (dst_reg[act_reg][15:10] == DESC_PAGE);
  // same spoke as the cpu: cpu goes first unless dma has waited too long
  assign conflict = cpu_req && (spoke_of(cpu_addr) == spoke_of(cur_addr));
  assign issue_ok = !conflict || (starve_reg >= STARVE_LIMIT);
  assign rd_done = (state_reg == ST_READ) && m_req.valid && m_ready;
  assign wr_done = (state_reg == ST_WRITE) &&
                   ((m_req.valid && m_ready) || dst_is_desc);
  assign last_byte = wr_done && (rem_reg[act_reg] == '0) && !cur_ctl.infinite;

  // transaction engine: read a byte, write it, return to idle to re-arbitrate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      act_reg <= '0;
      byte_reg <= '0;
      starve_reg <= '0;
      m_req <= '0;
    end
    else if (ce)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // preemption only here, so a running transaction always finishes
          if (sel_valid)
          begin
            act_reg <= sel_ch;
            state_reg <= ST_READ;
          end
        end
        ST_READ, ST_WRITE:
        begin
          if (rd_done)
          begin
            byte_reg <= m_rdata;
            m_req.valid <= 1'b0;
            state_reg <= ST_WRITE;
          end
          else if (wr_done)
          begin
            m_req.valid <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else if (!m_req.valid && issue_ok)
          begin
            // pool writes stay inside the hub and never reach a spoke
            m_req.valid <= 1'b1;
            m_req.write <= (state_reg == ST_WRITE);
            m_req.addr <= cur_addr;
            m_req.spoke <= spoke_of(cur_addr);
            m_req.wdata <= byte_reg;
            starve_reg <= '0;
          end
          else if (!m_req.valid)
            starve_reg <= starve_reg + 4'h1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // dma never waits more than the limit of conflicts
  starve_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    starve_reg <= STARVE_LIMIT) else $error("dma starve count over limit");
  // an issued request targets the spoke its address decodes to
  spoke_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(m_req.valid) |-> m_req.spoke == m_req.addr[SPOKE_MSB:SPOKE_LSB])
    else $error("request spoke does not match address");
  // a request is held until the spoke answers
  req_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    m_req.valid && !m_ready && ce |=> m_req.valid && $stable(m_req.addr))
    else $error("request dropped before answer");

  // cpu grant: decoded spoke, withheld only when dma owns that spoke
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_gnt <= 1'b0;
      cpu_spoke <= '0;
    end
    else if (ce)
    begin
      cpu_spoke <= spoke_of(cpu_addr);
      cpu_gnt <= cpu_req &&
                 !(m_req.valid && !m_ready && m_req.spoke == spoke_of(cpu_addr)) &&
                 !(!m_req.valid && state_reg != ST_IDLE && !rd_done && !wr_done &&
                   conflict && issue_ok);
    end
  end

  // cpu and dma may hold a spoke together only if the spokes differ
  shared_spoke_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_gnt && m_req.valid |-> cpu_spoke != m_req.spoke)
    else $error("cpu and dma granted on same spoke");

  ////////////////////////////////////////////////////////////////////////////
  // channel state: activation, descriptor load, progress, chaining
  logic [NCH-1:0] chain_set;
  always_comb
  begin
    chain_set = '0;
    if (last_byte && cfg_reg[act_reg].chain_en)
      chain_set[cfg_reg[act_reg].chain_ch] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_reg <= '0;
      busy_reg <= '0;
      load_reg <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        td_reg[c] <= '0;
        rem_reg[c] <= '0;
        src_reg[c] <= '0;
        dst_reg[c] <= '0;
      end
    end
    else if (ce)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        // an idle enabled channel takes its pending trigger
        if (pend_reg[c] && !busy_reg[c] && cfg_reg[c].en)
        begin
          busy_reg[c] <= 1'b1;
          load_reg[c] <= 1'b1;
          td_reg[c] <= cfg_reg[c].first_td;
        end
        // set wins over the clear of the same cycle
        if ((pend_reg[c] && !busy_reg[c] && cfg_reg[c].en) || cancel[c])
          pend_reg[c] <= 1'b0;
        if (trig_s2_reg[c] && !trig_s3_reg[c] || cpu_trig[c] || chain_set[c])
          pend_reg[c] <= 1'b1;
      end
      // descriptor fetched at grant time so rewrites made before it count
      if (start && load_reg[sel_ch])
      begin
        load_reg[sel_ch] <= 1'b0;
        rem_reg[sel_ch] <= ld_ctl.len_m1;
        src_reg[sel_ch] <= ld_adr.src;
        dst_reg[sel_ch] <= ld_adr.dst;
      end
      if (wr_done && busy_reg[act_reg])
      begin
        src_reg[act_reg] <= src_reg[act_reg] + 16'(cur_ctl.src_inc);
        dst_reg[act_reg] <= dst_reg[act_reg] + 16'(cur_ctl.dst_inc);
        if (!last_byte)
          rem_reg[act_reg] <= rem_reg[act_reg] - 16'h0001;
        else if (cur_ctl.last)
          busy_reg[act_reg] <= 1'b0;
        else
        begin
          td_reg[act_reg] <= cur_ctl.next_td;
          load_reg[act_reg] <= 1'b1;
        end
      end
      // cancel stops the channel; an issued byte still completes
      for (int c = 0; c < NCH; c++)
      begin
        if (cancel[c])
          busy_reg[c] <= 1'b0;
      end
    end
  end

  // a finished chain link moves to its named successor
  chain_link_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && last_byte && !cur_ctl.last && busy_reg[act_reg] && !cancel[act_reg]
    |=> td_reg[$past(act_reg)] == $past(cur_ctl.next_td) && load_reg[$past(act_reg)])
    else $error("chain did not follow link");
  // end of chain frees the channel
  chain_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && last_byte && cur_ctl.last && busy_reg[act_reg] |=> !busy_reg[$past(act_reg)])
    else $error("channel still busy after last descriptor");
  // a paused channel is never handed the engine
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |-> !pause_reg[sel_ch] && busy_reg[sel_ch])
    else $error("paused or idle channel granted");
  // levels 0 and 1 always beat fairness; strict order with fairness off
  prio_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && (lvl_any[0] || lvl_any[1] || !fair_en_reg) |-> use_lvl == top_lvl)
    else $error("higher priority level passed over");

  ////////////////////////////////////////////////////////////////////////////
  // descriptor pool: apb word writes and dma byte writes
  always_ff @(posedge pclk)
  begin
    if (ce)
    begin
      if (wr_done && dst_is_desc)
        desc_mem[dst_reg[act_reg][9:2]][dst_reg[act_reg][1:0]*8 +: 8] <= byte_reg;
      if (apb_wr && desc_hit)
        desc_mem[paddr[9:2]] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // end-of-descriptor interrupt pulses and busy flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq0 <= '0;
      irq1 <= '0;
      chan_busy <= '0;
    end
    else if (ce)
    begin
      irq0 <= '0;
      irq1 <= '0;
      chan_busy <= busy_reg;
      if (last_byte)
      begin
        irq0[act_reg] <= cur_ctl.irq0_en;
        irq1[act_reg] <= cur_ctl.irq1_en;
      end
    end
  end

  // interrupt outputs are single-cycle pulses
  irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (|irq0 || |irq1) |=> !(|irq0) && !(|irq1))
    else $error("interrupt pulse longer than one cycle");

endmodule : hdc_dma_hub
`default_nettype wire

// ### hdc_spoke_model.sv
// hdc_spoke_model: behavioural byte memory standing behind all eight spokes
`default_nettype none
module hdc_spoke_model
  import hdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire hdc_req_t m_req,
  input wire logic slow,
  output logic m_ready,
  output logic [7:0] m_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535]; // flat byte space, spoke taken from addr
  logic [2:0] wait_cnt; // wait states spent on the live request
  ////////////////////////////////////////////////////////////////////////
  // seed every byte with an address-dependent pattern
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
  end
  ////////////////////////////////////////////////////////////////////////
  // answer each byte promptly or after three wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_ready <= 1'b0;
      m_rdata <= 8'hA5;
      wait_cnt <= 3'h0;
    end
    else if (m_ready)
    begin
      // answer stands one cycle; stale data would hide a late sample
      m_ready <= 1'b0;
      m_rdata <= ~m_rdata;
    end
    else if (m_req.valid && (!slow || wait_cnt == 3'h3))
    begin
      m_ready <= 1'b1;
      wait_cnt <= 3'h0;
      if (m_req.write)
        mem[m_req.addr] <= m_req.wdata;
      m_rdata <= m_req.write ? ~m_rdata : mem[m_req.addr];
    end
    else
    begin
      // idle line toggles so a read outside the answer never matches
      wait_cnt <= m_req.valid ? wait_cnt + 3'h1 : 3'h0;
      m_rdata <= ~m_rdata;
    end
  end
endmodule // hdc_spoke_model
`default_nettype wire

// ### hdc_dma_hub_test.sv
// hdc_dma_hub_test: self-checking bench for the hub dma controller
`default_nettype none
module hdc_dma_hub_test;
  timeunit 1ns;
  timeprecision 100ps;
  import hdc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic cpu_req, cpu_gnt, m_ready, gnt_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NCH-1:0] trig_in, irq0, irq1, chan_busy;
  logic [15:0] cpu_addr;
  logic [2:0] cpu_spoke;
  logic [7:0] m_rdata;
  hdc_req_t m_req;
  int mismatches = 0;
  int cmp_count = 0;
  int n_irq0 = 0;
  int n_irq1 = 0;
  hdc_dma_hub u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_gnt(cpu_gnt), .cpu_spoke(cpu_spoke), .m_req(m_req),
    .m_ready(m_ready), .m_rdata(m_rdata), .irq0(irq0), .irq1(irq1), .chan_busy(chan_busy));
  hdc_spoke_model u_spoke (.pclk(pclk), .presetn(presetn), .m_req(m_req), .slow(slow),
    .m_ready(m_ready), .m_rdata(m_rdata));
  ////////////////////////////////////////////////////////////////////////
  // clock, watchdog and monitor
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
  always @(negedge pclk)
  begin
    if (presetn === 1'b1)
    begin
      n_irq0 += $countones(irq0);
      n_irq1 += $countones(irq1);
      gnt_seen |= (cpu_gnt === 1'b1);
      if (m_req.valid === 1'b1)
        chk(32'(m_req.spoke), 32'(m_req.addr[15:13]), "spoke decode");
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic hdc_td_ctrl_t mk(input logic [6:0] nx, input logic [3:0] f,
                                      input logic [15:0] lm);
    mk = '0;
    mk.next_td = nx;
    mk.len_m1 = lm;
    {mk.irq1_en, mk.irq0_en, mk.infinite, mk.last} = f;
    mk.src_inc = 1'b1;
    mk.dst_inc = 1'b1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // one apb transfer; answer taken at the edge that samples pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic td(input int i, input hdc_td_ctrl_t c, input logic [15:0] s,
                    input logic [15:0] dd);
    apb(1'b1, 12'(8 * i), 32'(c));
    apb(1'b1, 12'(8 * i + 4), {dd, s});
  endtask
  task automatic chan(input int ch, input logic [2:0] pr, input logic [6:0] first);
    hdc_ch_cfg_t c;
    c = CFG_RST;
    c.en = 1'b1;
    c.prio = pr;
    c.first_td = first;
    apb(1'b1, OFS_CFG + 12'(4 * ch), 32'(c));
  endtask
  task automatic wait_idle(input int ch);
    int n;
    n = 0;
    repeat (8) @(negedge pclk);
    while (chan_busy[ch] !== 1'b0 && n < 2000)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(chan_busy[ch]), 32'h0, "channel back to idle");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_regs();
    apb(1'b0, OFS_BUSY, '0);
    chk(rd, 32'h0, "busy after reset");
    apb(1'b0, 12'h4A0, '0);
    chk(32'(err), 32'h1, "unmapped read");
    apb(1'b1, OFS_CFG + 12'h060, 32'h3FFFF);
    chk(32'(err), 32'h1, "channel 24 config");
    cpu_addr <= 16'hA000;
    repeat (2) @(posedge pclk);
    chk(32'(cpu_spoke), 32'h5, "cpu spoke");
  endtask
  task automatic s_simple();
    int b;
    td(0, mk(7'h0, 4'b0101, 16'h3), 16'h0100, 16'h0210);
    chan(0, 3'h3, 7'h0);
    // cpu camps on the same spoke for the whole transfer
    cpu_req <= 1'b1;
    cpu_addr <= 16'h0080;
    b = n_irq0;
    apb(1'b1, OFS_TRIG, 32'h1);
    wait_idle(0);
    cpu_req <= 1'b0;
    for (int i = 0; i < 4; i++)
      chk(32'(u_spoke.mem[16'h0210 + i]), 32'(pat(16'h0100 + 16'(i))), "copy");
    chk(32'(n_irq0 - b), 32'h1, "end pulse");
    chk(32'(gnt_seen), 32'h1, "cpu granted");
  endtask
  task automatic s_chain();
    int b;
    td(2, mk(7'd3, 4'b0000, 16'h1), 16'h0300, 16'h6000);
    td(3, mk(7'd0, 4'b1001, 16'h0), 16'h0400, 16'h6100);
    chan(2, 3'h1, 7'd2);
    slow <= 1'b1;
    b = n_irq1;
    trig_in[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    trig_in[2] <= 1'b0;
    wait_idle(2);
    slow <= 1'b0;
    chk(32'(u_spoke.mem[16'h6000]), 32'(pat(16'h0300)), "gather 0");
    chk(32'(u_spoke.mem[16'h6001]), 32'(pat(16'h0301)), "gather 1");
    chk(32'(u_spoke.mem[16'h6100]), 32'(pat(16'h0400)), "gather 2");
    chk(32'(n_irq1 - b), 32'h1, "second line pulse");
  endtask
  task automatic s_repeat();
    int b;
    td(4, mk(7'd4, 4'b0100, 16'h0), 16'h0500, 16'h0700);
    chan(5, 3'h2, 7'd4);
    b = n_irq0;
    apb(1'b1, OFS_TRIG, 32'h20);
    repeat (200) @(negedge pclk);
    chk(32'(chan_busy[5]), 32'h1, "self link still live");
    chk(32'(n_irq0 - b > 2), 32'h1, "self link repeats");
    apb(1'b1, OFS_PAUSE, 32'h20);
    repeat (20) @(negedge pclk);
    b = n_irq0;
    repeat (100) @(negedge pclk);
    chk(32'(n_irq0 - b), 32'h0, "paused");
    apb(1'b1, OFS_CANCEL, 32'h20);
    wait_idle(5);
    apb(1'b1, OFS_PAUSE, 32'h0);
  endtask
  task automatic s_nested();
    // first descriptor rewrites the length byte of the second, then chains to it
    td(6, mk(7'd0, 4'b0001, 16'h0), 16'h0600, 16'h0800);
    td(5, mk(7'd6, 4'b0000, 16'h0), 16'h0510, 16'h4030);
    chan(7, 3'h4, 7'd5);
    apb(1'b1, OFS_TRIG, 32'h80);
    wait_idle(7);
    apb(1'b0, 12'h030, '0);
    chk(32'(rd[7:0]), 32'(pat(16'h0510)), "pool rewritten");
    chk(32'(u_spoke.mem[16'h084F]), 32'(pat(16'h064F)), "new length used");
    chk(32'(u_spoke.mem[16'h0850]), 32'(pat(16'h0850)), "stops at length");
  endtask
  task automatic s_prio();
    // level 0 overtakes a level 6 channel triggered in the same write
    td(7, mk(7'd0, 4'b0001, 16'h1F), 16'h0900, 16'h0A00);
    td(8, mk(7'd0, 4'b0001, 16'h1), 16'h0920, 16'h0B00);
    chan(8, 3'h6, 7'd7);
    chan(9, 3'h0, 7'd8);
    apb(1'b1, OFS_TRIG, 32'h300);
    wait_idle(9);
    chk(32'(chan_busy[8]), 32'h1, "low level still running");
    wait_idle(8);
    chk(32'(u_spoke.mem[16'h0A1F]), 32'(pat(16'h091F)), "low level done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    trig_in = '0;
    cpu_req = 1'b0;
    cpu_addr = '0;
    slow = 1'b0;
    gnt_seen = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_simple();
    s_chain();
    s_repeat();
    s_nested();
    s_prio();
    stop_test();
  end
endmodule // hdc_dma_hub_test
`default_nettype wire
